// ---- logic/cpu_status_flags.sv ----
// cpu status word: alu flags, repeat indicator, priority level, accumulator clip flags
//
// Functional notes
// - three-bit priority field in status bits 7:5
// - effective priority joins top bit: plus eight
// - top priority bit set blocks user interrupts
// - priority field read-only while nesting off set
// - bit 4 follows repeat loop activity
// - bit 3 set on negative result
// - bit 2 set on signed overflow
// - bit 1 zero, set by zero result, cleared by nonzero
// - bit 0 carry or borrow out of msb
// - status write sets clip flags, combined clears
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ns

module cpu_status_flags
  import status_flags_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input  wire logic              CLOCK_I,
  input  wire logic              RST_N_I,
  // register port
  input  wire logic [1:0]        REG_ADDR_I,
  input  wire logic [15:0]       REG_WDATA_I,
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  output logic      [15:0]       REG_RDATA_O,
  // datapath result strobe and flag-affect mask
  input  wire logic              ALU_VALID_I,
  input  wire logic [1:0]        ALU_OP_I,
  input  wire logic [DATA_W-1:0] ALU_A_I,
  input  wire logic [DATA_W-1:0] ALU_B_I,
  input  wire logic              ALU_CARRY_IN_I,
  input  wire logic [3:0]        ALU_AFFECT_I,
  // repeat loop and accumulator saturation events from the core
  input  wire logic              LOOP_ACTIVE_I,
  input  wire logic              ACC_A_CLIP_SET_I,
  input  wire logic              ACC_B_CLIP_SET_I,
  // status word and priority results
  output logic      [15:0]       STATUS_O,
  output logic      [3:0]        EFF_PRIORITY_O,
  output logic                   USER_IRQ_BLOCK_O
);

  // ==========================================================
  // alu evaluation
  function automatic logic [DATA_W:0] alu_eval(
    input logic [1:0]        op,
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b,
    input logic              cin
  );
    logic [DATA_W:0] r;
    r = '0;
    case (op)
      OP_ADD:   r = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
      // carry set means no borrow, as on the core's subtract
      OP_SUB:   r = {1'b0, a} + {1'b0, ~b} + {{DATA_W{1'b0}}, cin};
      OP_LOGIC: r = {1'b0, a & b};
      OP_PASS:  r = {1'b0, a};
      default:  r = '0;
    endcase
    return r;
  endfunction : alu_eval

  // ==========================================================
  // state
  logic [2:0]  prio_low_ff;
  logic [2:0]  nxt_prio_low;
  logic        prio_top_ff;
  logic        nxt_prio_top;
  logic        nesting_off_ff;
  logic        nxt_nesting_off;
  logic        loop_ff;
  logic        nxt_loop;
  logic        neg_ff;
  logic        nxt_neg;
  logic        wrap_ff;
  logic        nxt_wrap;
  logic        zero_ff;
  logic        nxt_zero;
  logic        carry_ff;
  logic        nxt_carry;
  logic        clip_a_ff;
  logic        nxt_clip_a;
  logic        clip_b_ff;
  logic        nxt_clip_b;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic [15:0] status_ff;
  logic [15:0] nxt_status;
  logic [3:0]  eff_ff;
  logic [3:0]  nxt_eff;
  logic        block_ff;
  logic        nxt_block;

  logic [DATA_W:0]   res_full;
  logic [DATA_W-1:0] res;
  logic              wr_status;
  logic              sign_a;
  logic              sign_b;

  assign res_full  = alu_eval(ALU_OP_I, ALU_A_I, ALU_B_I, ALU_CARRY_IN_I);
  assign res       = res_full[DATA_W-1:0];
  assign wr_status = REG_WR_I && (REG_ADDR_I == ADDR_STATUS);
  assign sign_a    = ALU_A_I[DATA_W-1];
  assign sign_b    = (ALU_OP_I == OP_SUB) ? ~ALU_B_I[DATA_W-1] : ALU_B_I[DATA_W-1];

  // ==========================================================
  // control fields
  always_comb
  begin
    nxt_prio_low    = prio_low_ff;
    nxt_prio_top    = prio_top_ff;
    nxt_nesting_off = nesting_off_ff;
    nxt_loop        = LOOP_ACTIVE_I;
    if (wr_status && !nesting_off_ff)
    begin
      nxt_prio_low = REG_WDATA_I[POS_PRIO_HI:POS_PRIO_LO];
    end
    if (REG_WR_I && (REG_ADDR_I == ADDR_CORE_CTRL))
    begin
      nxt_prio_top = REG_WDATA_I[POS_PRIO_TOP_BIT];
    end
    if (REG_WR_I && (REG_ADDR_I == ADDR_TRAP_CTRL))
    begin
      nxt_nesting_off = REG_WDATA_I[POS_NESTING_OFF];
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      prio_low_ff    <= PRIO_LOW_RESET;
      prio_top_ff    <= 1'b0;
      nesting_off_ff <= 1'b0;
      loop_ff        <= 1'b0;
    end
    else
    begin
      prio_low_ff    <= nxt_prio_low;
      prio_top_ff    <= nxt_prio_top;
      nesting_off_ff <= nxt_nesting_off;
      loop_ff        <= nxt_loop;
    end
  end

  // ==========================================================
  // arithmetic flags; a datapath result takes priority over a software write
  always_comb
  begin
    nxt_neg   = neg_ff;
    nxt_wrap  = wrap_ff;
    nxt_zero  = zero_ff;
    nxt_carry = carry_ff;
    if (wr_status)
    begin
      nxt_neg   = REG_WDATA_I[POS_NEGATIVE];
      nxt_wrap  = REG_WDATA_I[POS_SIGNED_WRAP];
      nxt_zero  = REG_WDATA_I[POS_ZERO];
      nxt_carry = REG_WDATA_I[POS_CARRY];
    end
    if (ALU_VALID_I)
    begin
      if (ALU_AFFECT_I[3])
      begin
        nxt_neg = res[DATA_W-1];
      end
      if (ALU_AFFECT_I[2])
      begin
        // same operand signs, different result sign
        nxt_wrap = (sign_a == sign_b) && (res[DATA_W-1] != sign_a);
      end
      if (ALU_AFFECT_I[1])
      begin
        // set by a zero result, cleared by a nonzero one
        nxt_zero = (res == '0) ? zero_ff : 1'b0;
        if (res == '0)
        begin
          nxt_zero = 1'b1;
        end
      end
      if (ALU_AFFECT_I[0])
      begin
        nxt_carry = res_full[DATA_W];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      neg_ff   <= 1'b0;
      wrap_ff  <= 1'b0;
      zero_ff  <= 1'b0;
      carry_ff <= 1'b0;
    end
    else
    begin
      neg_ff   <= nxt_neg;
      wrap_ff  <= nxt_wrap;
      zero_ff  <= nxt_zero;
      carry_ff <= nxt_carry;
    end
  end

  // ==========================================================
  // accumulator clip flags: hardware set wins over software clear
  always_comb
  begin
    nxt_clip_a = clip_a_ff;
    nxt_clip_b = clip_b_ff;
    if (wr_status)
    begin
      nxt_clip_a = REG_WDATA_I[POS_ACC_A_CLIP];
      nxt_clip_b = REG_WDATA_I[POS_ACC_B_CLIP];
      if (!REG_WDATA_I[POS_COMBINED_CLIP])
      begin
        nxt_clip_a = 1'b0;
        nxt_clip_b = 1'b0;
      end
    end
    // a bit-op read-modify-write can lose an event set here
    if (ACC_A_CLIP_SET_I)
    begin
      nxt_clip_a = 1'b1;
    end
    if (ACC_B_CLIP_SET_I)
    begin
      nxt_clip_b = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      clip_a_ff <= 1'b0;
      clip_b_ff <= 1'b0;
    end
    else
    begin
      clip_a_ff <= nxt_clip_a;
      clip_b_ff <= nxt_clip_b;
    end
  end

  // ==========================================================
  // outputs and read data
  always_comb
  begin
    nxt_status = STATUS_RESET;
    nxt_status[POS_ACC_A_CLIP]            = nxt_clip_a;
    nxt_status[POS_ACC_B_CLIP]            = nxt_clip_b;
    nxt_status[POS_COMBINED_CLIP]         = nxt_clip_a | nxt_clip_b;
    nxt_status[POS_PRIO_HI:POS_PRIO_LO]   = nxt_prio_low;
    nxt_status[POS_LOOP_ACTIVE]           = nxt_loop;
    nxt_status[POS_NEGATIVE]              = nxt_neg;
    nxt_status[POS_SIGNED_WRAP]           = nxt_wrap;
    nxt_status[POS_ZERO]                  = nxt_zero;
    nxt_status[POS_CARRY]                 = nxt_carry;
    nxt_eff   = {nxt_prio_top, nxt_prio_low};
    nxt_block = nxt_prio_top || (nxt_prio_low == PRIO_LOW_MAX);
    nxt_rdata = READ_ZERO;
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        ADDR_STATUS:    nxt_rdata = status_ff;
        ADDR_CORE_CTRL: nxt_rdata[POS_PRIO_TOP_BIT] = prio_top_ff;
        ADDR_TRAP_CTRL: nxt_rdata[POS_NESTING_OFF] = nesting_off_ff;
        ADDR_EFF_PRIO:  nxt_rdata[3:0] = eff_ff;
        default:        nxt_rdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rdata_ff  <= READ_ZERO;
      status_ff <= STATUS_RESET;
      eff_ff    <= 4'h0;
      block_ff  <= 1'b0;
    end
    else
    begin
      rdata_ff  <= nxt_rdata;
      status_ff <= nxt_status;
      eff_ff    <= nxt_eff;
      block_ff  <= nxt_block;
    end
  end

  assign REG_RDATA_O      = rdata_ff;
  assign STATUS_O         = status_ff;
  assign EFF_PRIORITY_O   = eff_ff;
  assign USER_IRQ_BLOCK_O = block_ff;

endmodule : cpu_status_flags

// ---- logic/status_flags_pkg.sv ----
// package: register map, field positions and reset values of the status word block
package status_flags_pkg;

  // ==========================================================
  // register indices on the plain register port
  localparam logic [1:0] ADDR_STATUS    = 2'h0;
  localparam logic [1:0] ADDR_CORE_CTRL = 2'h1;
  localparam logic [1:0] ADDR_TRAP_CTRL = 2'h2;
  localparam logic [1:0] ADDR_EFF_PRIO  = 2'h3;

  // ==========================================================
  // status word fields
  localparam int POS_ACC_A_CLIP    = 15;
  localparam int POS_ACC_B_CLIP    = 14;
  localparam int POS_COMBINED_CLIP = 13;
  localparam int POS_PRIO_HI       = 7;
  localparam int POS_PRIO_LO       = 5;
  localparam int POS_LOOP_ACTIVE   = 4;
  localparam int POS_NEGATIVE      = 3;
  localparam int POS_SIGNED_WRAP   = 2;
  localparam int POS_ZERO          = 1;
  localparam int POS_CARRY         = 0;

  // core control and trap control fields
  localparam int POS_PRIO_TOP_BIT = 3;
  localparam int POS_NESTING_OFF  = 15;

  // ==========================================================
  // reset values and codes
  localparam logic [2:0]  PRIO_LOW_RESET  = 3'h0;
  localparam logic [2:0]  PRIO_LOW_MAX    = 3'h7;
  localparam logic [15:0] STATUS_RESET    = 16'h0000;
  localparam logic [15:0] READ_ZERO       = 16'h0000;

  // alu operation kinds presented by the datapath
  typedef enum logic [1:0]
  {
    OP_ADD   = 2'b00,
    OP_SUB   = 2'b01,
    OP_LOGIC = 2'b10,
    OP_PASS  = 2'b11
  } alu_op_t;

endpackage : status_flags_pkg

// ---- tb/cpu_status_flags_tb.sv ----
// testbench: register, datapath and priority checks of the status word block
`timescale 1ns/1ns
module cpu_status_flags_tb
  import status_flags_pkg::*;
;
  // ==========
  // stimulus and helpers
  logic        clk, rst_n, wr, rd, valid, cin, loop, set_a, set_b, block;
  logic [1:0]  addr, op;
  logic [15:0] wdata, a, b, rdata, status;
  logic [3:0]  aff, eff;
  int          err_count, check_count;

  cpu_status_flags u_dut (
    .CLOCK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .ALU_VALID_I(valid), .ALU_OP_I(op), .ALU_A_I(a),
    .ALU_B_I(b), .ALU_CARRY_IN_I(cin), .ALU_AFFECT_I(aff), .LOOP_ACTIVE_I(loop),
    .ACC_A_CLIP_SET_I(set_a), .ACC_B_CLIP_SET_I(set_b), .STATUS_O(status),
    .EFF_PRIORITY_O(eff), .USER_IRQ_BLOCK_O(block)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr_reg(input logic [1:0] ad, input logic [15:0] d);
    @(posedge clk);
    addr  <= ad;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  task automatic rd_reg(input logic [1:0] ad);
    @(posedge clk);
    addr <= ad;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
  endtask : rd_reg

  // e is the expected {neg, wrap, zero, carry} after the op
  task automatic alu(input logic [1:0] o, input logic [15:0] x, input logic [15:0] y,
                     input logic c, input logic [3:0] m, input logic [3:0] e);
    @(posedge clk);
    op    <= o;
    a     <= x;
    b     <= y;
    cin   <= c;
    aff   <= m;
    valid <= 1'b1;
    @(posedge clk);
    valid <= 1'b0;
    #1;
    chk("flags", {12'h000, e}, {12'h000, status[3:0]});
  endtask : alu

  // ==========
  // tests
  initial
  begin
    {wr, rd, valid, cin, loop, set_a, set_b} = '0;
    {addr, op, aff} = '0;
    {wdata, a, b} = '0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("reset", STATUS_RESET, status);
    alu(OP_ADD, 16'h7fff, 16'h0001, 1'b0, 4'hf, 4'hc);
    alu(OP_ADD, 16'hffff, 16'h0001, 1'b0, 4'hf, 4'h3);
    alu(OP_SUB, 16'h0005, 16'h0005, 1'b1, 4'hf, 4'h3);
    alu(OP_SUB, 16'h8000, 16'h0001, 1'b1, 4'hf, 4'h5);
    alu(OP_LOGIC, 16'hf0f0, 16'h0f0f, 1'b0, 4'ha, 4'h7);
    alu(OP_PASS, 16'h1234, 16'h0000, 1'b0, 4'h0, 4'h7);
    alu(OP_PASS, 16'h8000, 16'h0000, 1'b0, 4'h8, 4'hf);
    alu(OP_PASS, 16'h0001, 16'h0000, 1'b0, 4'h2, 4'hd);
    alu(OP_ADD, 16'h0001, 16'h0001, 1'b1, 4'h1, 4'hc);
    $display("test flags done");
    wr_reg(ADDR_CORE_CTRL, 16'h0008);
    for (int f = 0; f < 8; f++)
    begin
      wr_reg(ADDR_STATUS, 16'(f) << 5);
      chk("eff", 16'(8 + f), {12'h000, eff});
      chk("block", 16'h0001, {15'h0000, block});
    end
    rd_reg(ADDR_CORE_CTRL);
    chk("core_rd", 16'h0008, rdata);
    wr_reg(ADDR_CORE_CTRL, 16'h0000);
    wr_reg(ADDR_STATUS, 16'h00c0);
    chk("block", 16'h0000, {15'h0000, block});
    wr_reg(ADDR_STATUS, 16'h00e0);
    chk("block", 16'h0001, {15'h0000, block});
    chk("eff", 16'h0007, {12'h000, eff});
    rd_reg(ADDR_EFF_PRIO);
    chk("eff_rd", 16'h0007, rdata);
    @(posedge clk);
    #1;
    chk("rd_idle", 16'h0000, rdata);
    $display("test priority done");
    wr_reg(ADDR_TRAP_CTRL, 16'h8000);
    wr_reg(ADDR_STATUS, 16'h0020);
    rd_reg(ADDR_STATUS);
    chk("prio_rd", 16'h0007, {13'h0000, rdata[7:5]});
    rd_reg(ADDR_TRAP_CTRL);
    chk("trap_rd", 16'h8000, rdata);
    wr_reg(ADDR_TRAP_CTRL, 16'h0000);
    wr_reg(ADDR_STATUS, 16'h0020);
    chk("prio", 16'h0001, {13'h0000, status[7:5]});
    $display("test lock done");
    @(posedge clk);
    loop <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("loop", 16'h0001, {15'h0000, status[4]});
    @(posedge clk);
    loop <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("loop", 16'h0000, {15'h0000, status[4]});
    @(posedge clk);
    set_a <= 1'b1;
    @(posedge clk);
    set_a <= 1'b0;
    #1;
    chk("clip", 16'h0005, {13'h0000, status[15:13]});
    wr_reg(ADDR_STATUS, 16'h0000);
    chk("clip", 16'h0000, {13'h0000, status[15:13]});
    wr_reg(ADDR_STATUS, 16'h6000);
    chk("clip", 16'h0003, {13'h0000, status[15:13]});
    // same cycle: write clears, hardware set and alu result must win
    @(posedge clk);
    addr  <= ADDR_STATUS;
    wdata <= 16'h0000;
    wr    <= 1'b1;
    set_b <= 1'b1;
    op    <= OP_PASS;
    a     <= 16'h8000;
    aff   <= 4'h8;
    valid <= 1'b1;
    @(posedge clk);
    {wr, set_b, valid} <= '0;
    #1;
    chk("race", 16'h6008, status);
    $display("test loop and clip done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("reset", STATUS_RESET, status);
    chk("eff", 16'h0000, {12'h000, eff});
    $display("test mid reset done");
    wrap_up();
  end

  initial
  begin
    repeat (2000) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule : cpu_status_flags_tb

// ---- tb/status_flags_monitor.sv ----
// checker: status flag and priority assertions on the top ports
`timescale 1ns/1ns
module status_flags_monitor
  import status_flags_pkg::*;
#(
  parameter int DATA_W = 16
)
(
  input wire logic              CLOCK_I,
  input wire logic              RST_N_I,
  input wire logic              REG_WR_I,
  input wire logic              ALU_VALID_I,
  input wire logic [1:0]        ALU_OP_I,
  input wire logic [DATA_W-1:0] ALU_A_I,
  input wire logic [DATA_W-1:0] ALU_B_I,
  input wire logic              ALU_CARRY_IN_I,
  input wire logic [3:0]        ALU_AFFECT_I,
  input wire logic              LOOP_ACTIVE_I,
  input wire logic [15:0]       STATUS_O,
  input wire logic [3:0]        EFF_PRIORITY_O,
  input wire logic              USER_IRQ_BLOCK_O
);
  // ==========
  // reference sum
  logic [DATA_W:0] sum;
  logic            add_go;
  logic            wrap;
  assign sum = ALU_A_I + ALU_B_I + ALU_CARRY_IN_I;
  assign add_go = ALU_VALID_I && ALU_OP_I == OP_ADD;
  assign wrap = ALU_A_I[DATA_W-1] == ALU_B_I[DATA_W-1] && sum[DATA_W-1] != ALU_A_I[DATA_W-1];
  // ==========
  // properties
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);
  eff_field_a: assert property (EFF_PRIORITY_O[2:0] == STATUS_O[7:5])
    else $error("effective level low bits differ");
  irq_block_a: assert property (USER_IRQ_BLOCK_O ==
    (EFF_PRIORITY_O[3] || STATUS_O[7:5] == 3'h7)) else $error("user interrupt block wrong");
  loop_flag_a: assert property (!REG_WR_I |=> STATUS_O[4] == $past(LOOP_ACTIVE_I))
    else $error("loop flag does not follow");
  neg_flag_a: assert property (ALU_VALID_I && ALU_AFFECT_I[3] && ALU_OP_I == OP_PASS
    |=> STATUS_O[3] == $past(ALU_A_I[DATA_W-1])) else $error("negative flag wrong");
  zero_flag_a: assert property (ALU_VALID_I && ALU_AFFECT_I[1] && ALU_OP_I == OP_PASS
    |=> STATUS_O[1] == ($past(ALU_A_I) == '0)) else $error("zero flag wrong");
  wrap_flag_a: assert property (add_go && ALU_AFFECT_I[2] |=> STATUS_O[2] == $past(wrap))
    else $error("signed wrap flag wrong");
  carry_flag_a: assert property (add_go && ALU_AFFECT_I[0]
    |=> STATUS_O[0] == $past(sum[DATA_W])) else $error("carry flag wrong");
  flags_hold_a: assert property (!ALU_VALID_I && !REG_WR_I |=> $stable(STATUS_O[3:0]))
    else $error("flags moved without cause");
  clip_join_a: assert property (STATUS_O[13] == (STATUS_O[15] || STATUS_O[14]))
    else $error("combined clip flag wrong");
endmodule : status_flags_monitor

bind cpu_status_flags status_flags_monitor #(.DATA_W(DATA_W)) u_mon (
  .CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .REG_WR_I(REG_WR_I), .ALU_VALID_I(ALU_VALID_I),
  .ALU_OP_I(ALU_OP_I), .ALU_A_I(ALU_A_I), .ALU_B_I(ALU_B_I), .ALU_CARRY_IN_I(ALU_CARRY_IN_I),
  .ALU_AFFECT_I(ALU_AFFECT_I), .LOOP_ACTIVE_I(LOOP_ACTIVE_I), .STATUS_O(STATUS_O),
  .EFF_PRIORITY_O(EFF_PRIORITY_O), .USER_IRQ_BLOCK_O(USER_IRQ_BLOCK_O)
);
